//--- pkg/slt_pkg.sv
// Purpose: Shared constants and types for the scan logic timer unit
// Assumes: 250 MHz clock, 32-bit APB register access
// Notes: Control/status word layout is shared by all three timer channels
package slt_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned TENTH_NS = 100000000;
  localparam int unsigned TENTH_CYCLES = TENTH_NS / 4;
  localparam int unsigned TENTHS_PER_SEC = 10;
  localparam int unsigned SCAN_CYCLES = 256;
  // Control/status bit positions
  localparam int CS_START = 0;
  localparam int CS_DONE = 1;
  localparam int CS_BUSY = 2;
  localparam int CS_HIST = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_SEC_PRESET = 8'h00;
  localparam logic [7:0] OFS_SEC_END = 8'h04;
  localparam logic [7:0] OFS_SEC_CTRL = 8'h08;
  localparam logic [7:0] OFS_TEN_PRESET = 8'h0C;
  localparam logic [7:0] OFS_TEN_END = 8'h10;
  localparam logic [7:0] OFS_TEN_CTRL = 8'h14;
  localparam logic [7:0] OFS_K_PRESET = 8'h18;
  localparam logic [7:0] OFS_K_END = 8'h1C;
  localparam logic [7:0] OFS_K_CTRL = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_TIME_NOW = 8'h2C;
  localparam logic [7:0] OFS_RELOAD = 8'h30;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0] RST_MASK = 3'h0;
  // Status word
  typedef struct packed {
    logic hist;
    logic busy;
    logic done;
  } slt_stat_t;
  // APB request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } slt_apb_req_t;
endpackage : slt_pkg

//--- design/slt_timebase.sv
// Purpose: Free-running tick generators and time counters
// Assumes: Single clock, synchronous active-low reset
// Notes: Produces scan strobe, tenths count and seconds count
`timescale 1ns/100ps
module slt_timebase #(
  parameter int unsigned TENTH_DIV = slt_pkg::TENTH_CYCLES,
  parameter int unsigned SCAN_DIV = slt_pkg::SCAN_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Ticks
  output logic scan_tick,
  output logic [15:0] tenths_now,
  output logic [15:0] secs_now
);
  import slt_pkg::*;

  // Refuse dividers that the counters cannot serve
  if (TENTH_DIV < 2 || SCAN_DIV < 2) begin : g_bad_div
    $error("dividers must be at least 2");
  end

  logic [31:0] div_reg;
  logic [31:0] scan_reg;
  logic [3:0] sub_reg;

  // Tenths divider; seconds follow every tenth tick count of ten
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= 32'h0;
      sub_reg <= 4'h0;
      tenths_now <= 16'h0;
      secs_now <= 16'h0;
    end else if (div_reg == TENTH_DIV - 1) begin
      div_reg <= 32'h0;
      tenths_now <= tenths_now + 16'h1;
      if (sub_reg == 4'(TENTHS_PER_SEC - 1)) begin
        sub_reg <= 4'h0;
        secs_now <= secs_now + 16'h1;
      end else begin
        sub_reg <= sub_reg + 4'h1;
      end
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end

  // Scan strobe, one cycle per logic scan
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scan_reg <= 32'h0;
      scan_tick <= 1'b0;
    end else begin
      scan_tick <= (scan_reg == SCAN_DIV - 1);
      scan_reg <= (scan_reg == SCAN_DIV - 1) ? 32'h0 : scan_reg + 32'h1;
    end
  end
endmodule : slt_timebase

//--- design/slt_channel.sv
// Purpose: One timer channel evaluated once per scan
// Assumes: Time input wraps modulo 65536
// Notes: ONE_SHOT models the load-once limitation of the register-preset timers
`timescale 1ns/100ps
module slt_channel #(
  parameter bit ONE_SHOT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Scan and time
  input wire logic scan_tick,
  input wire logic [15:0] time_now,
  input wire logic reload,
  // Control word fields
  input wire logic start,
  input wire logic [15:0] preset,
  // Results
  output logic [15:0] end_time,
  output slt_pkg::slt_stat_t stat,
  output logic done_pulse
);
  import slt_pkg::*;

  logic used_reg;
  logic rise;
  logic fall;

  // Edges come from bit0 against the history bit
  assign rise = start && !stat.hist;
  assign fall = !start && stat.hist;

  // Scan evaluation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat <= '0;
      end_time <= RST_WORD;
      used_reg <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (reload) used_reg <= 1'b0;
      if (scan_tick) begin
        stat.hist <= start;
        if (rise && !(ONE_SHOT && used_reg)) begin
          end_time <= time_now + preset;
          stat.busy <= 1'b1;
          stat.done <= 1'b0;
          used_reg <= 1'b1;
        end else if (fall) begin
          stat.busy <= 1'b0;
          stat.done <= 1'b0;
        end else if (stat.busy && time_now == end_time) begin
          stat.busy <= 1'b0;
          stat.done <= 1'b1;
          done_pulse <= 1'b1;
        end
      end
    end
  end

  a_done_on_end: assert property (@(posedge clk) disable iff (!rst_n)
    scan_tick && stat.busy && start && stat.hist && time_now == end_time
    |=> stat.done && !stat.busy) else $error("done not set at end time");
  a_fall_clears: assert property (@(posedge clk) disable iff (!rst_n)
    scan_tick && fall |=> !stat.done && !stat.busy)
    else $error("falling start did not clear");
  a_hist_follows: assert property (@(posedge clk) disable iff (!rst_n)
    scan_tick |=> stat.hist == $past(start)) else $error("history bit wrong");
  a_end_computed: assert property (@(posedge clk) disable iff (!rst_n)
    scan_tick && rise && !used_reg |=> stat.busy && end_time == $past(time_now)
    + $past(preset)) else $error("end time wrong");
  a_one_shot: assert property (@(posedge clk) disable iff (!rst_n)
    ONE_SHOT && used_reg && !reload && scan_tick && rise && !stat.busy
    |=> !stat.busy) else $error("timer re-enabled");
endmodule : slt_channel

//--- design/slt_top.sv
// Purpose: Scan logic timer unit with APB access to its scratch words
// Assumes: APB master per protocol, 250 MHz MCLK, synchronous RST_N
// Notes: Three channels: seconds/register preset, tenths/register preset,
//   seconds/constant preset; end times wrap modulo 65536
//
// Behaviour
// - Seconds timer counts to register preset
// - Tenths timer counts tenths; preset is seconds*10
// - Constant timer counts seconds to constant; here preset word OFS_K_PRESET, reset to CONST_PRESET and writable
// - Register timers write end time to second word
// - Constant timer writes end time to first word; here second word OFS_K_END, after preset word OFS_K_PRESET
// - Register timers use third word as control
// - Constant timer uses second word as control; here third word OFS_K_CTRL, after OFS_K_PRESET and OFS_K_END
// - Bit0 rising edge starts the timer
// - Bit0 falling edge stops the timer
// - Done bit1 set at end time
// - Done cleared by bit0 low or reset
// - Busy bit2 set while counting, cleared at end
// - Bit3 keeps previous bit0; bit4 reserved
// - Register timers run once until reload
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
module slt_top #(
  parameter int unsigned TENTH_DIV = slt_pkg::TENTH_CYCLES,
  parameter int unsigned SCAN_DIV = slt_pkg::SCAN_CYCLES,
  parameter logic [15:0] CONST_PRESET = 16'h0005
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ
);
  import slt_pkg::*;

  slt_apb_req_t req;
  logic scan_tick;
  logic [15:0] tenths_now;
  logic [15:0] secs_now;
  logic [15:0] sec_preset_reg;
  logic [15:0] ten_preset_reg;
  logic [15:0] k_preset_reg;
  logic [2:0] start_reg;
  logic reload_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [15:0] end_sec;
  logic [15:0] end_ten;
  logic [15:0] end_k;
  slt_stat_t st_sec;
  slt_stat_t st_ten;
  slt_stat_t st_k;
  logic [2:0] done_ev;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rdata_next;
  logic [2:0] irq_clr;
  logic [2:0] irq_stat_next;

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
  // Zero-wait slave: access phase completes in one cycle
  assign acc = req.sel && req.enable;
  assign wr = acc && req.write;
  assign rd = acc && !req.write;

  // Time base shared by all channels
  slt_timebase #(.TENTH_DIV(TENTH_DIV), .SCAN_DIV(SCAN_DIV)) u_tb (
    .clk(MCLK),
    .rst_n(RST_N),
    .scan_tick(scan_tick),
    .tenths_now(tenths_now),
    .secs_now(secs_now)
  );

  // Seconds timer with register preset
  slt_channel #(.ONE_SHOT(1'b1)) u_sec (
    .clk(MCLK),
    .rst_n(RST_N),
    .scan_tick(scan_tick),
    .time_now(secs_now),
    .reload(reload_reg),
    .start(start_reg[0]),
    .preset(sec_preset_reg),
    .end_time(end_sec),
    .stat(st_sec),
    .done_pulse(done_ev[0])
  );

  // Tenths timer; tenths time base makes the preset seconds*10
  slt_channel #(.ONE_SHOT(1'b1)) u_ten (
    .clk(MCLK),
    .rst_n(RST_N),
    .scan_tick(scan_tick),
    .time_now(tenths_now),
    .reload(reload_reg),
    .start(start_reg[1]),
    .preset(ten_preset_reg),
    .end_time(end_ten),
    .stat(st_ten),
    .done_pulse(done_ev[1])
  );

  // Constant-preset timer, free to restart
  slt_channel #(.ONE_SHOT(1'b0)) u_k (
    .clk(MCLK),
    .rst_n(RST_N),
    .scan_tick(scan_tick),
    .time_now(secs_now),
    .reload(reload_reg),
    .start(start_reg[2]),
    .preset(k_preset_reg),
    .end_time(end_k),
    .stat(st_k),
    .done_pulse(done_ev[2])
  );

  // Preset words, writable by the logic program
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sec_preset_reg <= RST_WORD;
      ten_preset_reg <= RST_WORD;
      k_preset_reg <= CONST_PRESET;
    end else if (wr) begin
      if (req.addr == OFS_SEC_PRESET) sec_preset_reg <= req.wdata[15:0];
      if (req.addr == OFS_TEN_PRESET) ten_preset_reg <= req.wdata[15:0];
      if (req.addr == OFS_K_PRESET) k_preset_reg <= req.wdata[15:0];
    end
  end

  // Start bits live in bit0 of each control word; other bits are read-only
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      start_reg <= 3'h0;
    end else if (wr) begin
      if (req.addr == OFS_SEC_CTRL) start_reg[0] <= req.wdata[CS_START];
      if (req.addr == OFS_TEN_CTRL) start_reg[1] <= req.wdata[CS_START];
      if (req.addr == OFS_K_CTRL) start_reg[2] <= req.wdata[CS_START];
    end
  end

  // Reload strobe re-arms the one-shot timers
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      reload_reg <= 1'b0;
    end else begin
      reload_reg <= wr && req.addr == OFS_RELOAD && req.wdata[0];
    end
  end

  // Sticky done events; a read clears only the bits its answer carried,
  // so an event landing between setup and access is kept; a set wins
  assign irq_clr = {3{rd && req.addr == OFS_IRQ_STAT}} & PRDATA[2:0];
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | done_ev;
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      irq_stat_reg <= RST_MASK;
      irq_mask_reg <= RST_MASK;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr && req.addr == OFS_IRQ_MASK) irq_mask_reg <= req.wdata[2:0];
    end
  end

  // Interrupt output registered to stay glitch free
  always_ff @(posedge MCLK) begin
    if (!RST_N) IRQ <= 1'b0;
    else IRQ <= |(irq_stat_next & irq_mask_reg);
  end

  // Read mux; bit4 and above of control words read zero
  always_comb begin
    rdata_next = 32'h0;
    mapped = 1'b1;
    case (req.addr)
      OFS_SEC_PRESET: rdata_next[15:0] = sec_preset_reg;
      OFS_SEC_END: rdata_next[15:0] = end_sec;
      OFS_SEC_CTRL: rdata_next[3:0] = {st_sec, start_reg[0]};
      OFS_TEN_PRESET: rdata_next[15:0] = ten_preset_reg;
      OFS_TEN_END: rdata_next[15:0] = end_ten;
      OFS_TEN_CTRL: rdata_next[3:0] = {st_ten, start_reg[1]};
      OFS_K_PRESET: rdata_next[15:0] = k_preset_reg;
      OFS_K_END: rdata_next[15:0] = end_k;
      OFS_K_CTRL: rdata_next[3:0] = {st_k, start_reg[2]};
      OFS_IRQ_STAT: rdata_next[2:0] = irq_stat_reg;
      OFS_IRQ_MASK: rdata_next[2:0] = irq_mask_reg;
      OFS_TIME_NOW: rdata_next = {tenths_now, secs_now};
      OFS_RELOAD: rdata_next = 32'h0;
      default: mapped = 1'b0;
    endcase
  end

  // Registered APB answer: ready in the first cycle of the access phase
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= req.sel && !req.enable;
      PSLVERR <= req.sel && !req.enable && !mapped;
      PRDATA <= (req.sel && !req.enable && !req.write) ? rdata_next : 32'h0;
    end
  end

  a_irq_level: assert property (@(posedge MCLK) disable iff (!RST_N)
    (irq_stat_reg & irq_mask_reg) != 3'h0 && !rd |=> IRQ)
    else $error("irq not raised");
  a_ctrl_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr && PREADY && req.addr == OFS_SEC_CTRL |=> start_reg[0] == $past(req.wdata[0]))
    else $error("start bit not stored");
  a_ready_pulse: assert property (@(posedge MCLK) disable iff (!RST_N)
    PSEL && !PENABLE |=> PREADY) else $error("ready late");

  // Answer shape: error only with ready, data zero outside an answer
  a_err_with_ready: assert property (@(posedge MCLK) disable iff (!RST_N)
    PSLVERR |-> PREADY) else $error("error without ready");
  a_rdata_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
    !PREADY |-> PRDATA == 32'h0) else $error("read data outside answer");
  a_ready_single: assert property (@(posedge MCLK) disable iff (!RST_N)
    PREADY && PSEL && PENABLE |=> !PREADY) else $error("ready held too long");

  // Control words read zero from bit4 up
  a_ctrl_reserved: assert property (@(posedge MCLK) disable iff (!RST_N)
    PREADY && !PWRITE && (PADDR == OFS_SEC_CTRL || PADDR == OFS_TEN_CTRL ||
    PADDR == OFS_K_CTRL) |-> PRDATA[31:4] == 28'h0) else $error("reserved bits set");

  // End words are sixteen bits; the upper half reads zero
  a_end_upper: assert property (@(posedge MCLK) disable iff (!RST_N)
    PREADY && !PWRITE && (PADDR == OFS_SEC_END || PADDR == OFS_TEN_END ||
    PADDR == OFS_K_END) |-> PRDATA[31:16] == 16'h0) else $error("end word too wide");

  // Busy and done exclude each other, and both need the history bit
  a_sec_flags: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st_sec.busy || st_sec.done) |-> st_sec.hist && !(st_sec.busy && st_sec.done))
    else $error("seconds flags inconsistent");
  a_ten_flags: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st_ten.busy || st_ten.done) |-> st_ten.hist && !(st_ten.busy && st_ten.done))
    else $error("tenths flags inconsistent");
  a_k_flags: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st_k.busy || st_k.done) |-> st_k.hist && !(st_k.busy && st_k.done))
    else $error("constant flags inconsistent");

  // End times and status move only on scan ticks
  a_end_on_scan: assert property (@(posedge MCLK) disable iff (!RST_N)
    !scan_tick |=> $stable(end_sec) && $stable(end_ten) && $stable(end_k))
    else $error("end time moved off scan");
  a_stat_on_scan: assert property (@(posedge MCLK) disable iff (!RST_N)
    !scan_tick |=> $stable(st_sec) && $stable(st_ten) && $stable(st_k))
    else $error("status moved off scan");

  // Start bits move only by a write to their own control word
  a_sec_start_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(wr && req.addr == OFS_SEC_CTRL) |=> $stable(start_reg[0]))
    else $error("seconds start moved");
  a_ten_start_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(wr && req.addr == OFS_TEN_CTRL) |=> $stable(start_reg[1]))
    else $error("tenths start moved");
  a_k_start_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(wr && req.addr == OFS_K_CTRL) |=> $stable(start_reg[2]))
    else $error("constant start moved");

  // Presets and mask move only by their own writes
  a_sec_preset_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(wr && req.addr == OFS_SEC_PRESET) |=> $stable(sec_preset_reg))
    else $error("seconds preset moved");
  a_ten_preset_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(wr && req.addr == OFS_TEN_PRESET) |=> $stable(ten_preset_reg))
    else $error("tenths preset moved");
  a_k_preset_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(wr && req.addr == OFS_K_PRESET) |=> $stable(k_preset_reg))
    else $error("constant preset moved");
  a_mask_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(wr && req.addr == OFS_IRQ_MASK) |=> $stable(irq_mask_reg))
    else $error("mask moved");

  // Reload strobe comes only from its own write
  a_reload_src: assert property (@(posedge MCLK) disable iff (!RST_N)
    reload_reg |-> $past(wr && req.addr == OFS_RELOAD && req.wdata[0]))
    else $error("reload without write");

  // Seconds advance only together with a tenths step
  a_sec_on_tenth: assert property (@(posedge MCLK) disable iff (!RST_N)
    $changed(secs_now) |-> $changed(tenths_now)) else $error("seconds off tenths base");

  // Events are sticky; a read clears only what its answer carried
  a_irq_set_wins: assert property (@(posedge MCLK) disable iff (!RST_N)
    done_ev != 3'h0 |=> (irq_stat_reg & $past(done_ev)) == $past(done_ev))
    else $error("done event lost");
  a_irq_read_clears: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd && req.addr == OFS_IRQ_STAT && done_ev == 3'h0
    |=> (irq_stat_reg & $past(PRDATA[2:0])) == 3'h0) else $error("status not cleared");
  a_irq_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
    (irq_stat_reg & irq_mask_reg) == 3'h0 && done_ev == 3'h0 |=> !IRQ)
    else $error("irq without cause");
endmodule : slt_top

//--- bench/slt_prog_model.sv
// Purpose: Stand-in for the logic program that owns the scratch words
// Assumes: Zero-or-more wait APB slave, one transfer at a time
// Notes: Bench calls xfer hierarchically; a hung slave returns unknown data
`timescale 1ns/100ps
module slt_prog_model (
  // Clock
  input wire logic clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // One transfer; request held until pready seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er, output bit tmo);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    tmo = (pready !== 1'b1);
    rd = tmo ? 32'hXXXXXXXX : prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look like a held value
    pwdata <= ~d;
  endtask : xfer
endmodule : slt_prog_model

//--- bench/scan_logic_timer_unit_tb.sv
// Purpose: Self-checking bench for the scan logic timer unit
// Assumes: Short tenth (4 cycles) and scan (2 cycles) divisors
// Notes: Time windows allow for scan and bus latency, never early done
`timescale 1ns/100ps
module scan_logic_timer_unit_tb;
  import slt_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int err_total = 0;
  int num_checks = 0;

  // Clock, 4 ns period
  always #2 mclk = ~mclk;

  slt_top #(.TENTH_DIV(4), .SCAN_DIV(2), .CONST_PRESET(16'h0003)) i_dut (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq));
  slt_prog_model i_prog (
    .clk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // A transfer that never completes ends the run
  task automatic bus_check(input bit tmo);
    if (tmo) begin
      err_total++;
      $display("ERROR %0t bus transfer timed out", $time);
      give_verdict();
    end
  endtask : bus_check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bit tmo;
    i_prog.xfer(1'b1, a, d, r, er, tmo);
    bus_check(tmo);
  endtask : wr

  task automatic rdw(input logic [7:0] a, output logic [31:0] d);
    bit tmo;
    i_prog.xfer(1'b0, a, 32'h00000000, d, er, tmo);
    bus_check(tmo);
  endtask : rdw

  // Bounded poll until masked word matches
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 400; i++) begin
      rdw(a, r);
      if ((r & m) === v) return;
    end
    chk(r & m, v, "poll timeout");
    give_verdict();
  endtask : poll

  // Reset state and an unmapped access
  task automatic t_reset;
    logic [31:0] r;
    logic [7:0] ctl [3] = '{OFS_SEC_CTRL, OFS_TEN_CTRL, OFS_K_CTRL};
    chk({31'h0, irq}, 32'h1 & 32'h0, "irq after reset");
    foreach (ctl[i]) begin
      rdw(ctl[i], r);
      chk(r, 32'h0, "ctrl after reset");
    end
    rdw(8'h40, r);
    chk({r[30:0], er}, 32'h1, "unmapped read");
    $display("t_reset done");
  endtask : t_reset

  // Full run of one channel: preset, start, end time, done, stop
  task automatic run_chan(input logic [7:0] ctl, input logic [15:0] pre, input bit tn,
                          input logic [31:0] ib, input bit irq_on);
    logic [31:0] t0, e, c, t1;
    logic [15:0] dif;
    if (ctl != OFS_K_CTRL) wr(ctl - 8'h08, {16'h0000, pre});
    rdw(OFS_TIME_NOW, t0);
    wr(ctl, 32'h00000001);
    poll(ctl, 32'h00000004, 32'h00000004);
    rdw(ctl - 8'h04, e);
    dif = e[15:0] - (tn ? t0[31:16] : t0[15:0]) - pre;
    chk({31'h0, dif <= 16'h0003}, 32'h1, "end time");
    poll(ctl, 32'h00000006, 32'h00000002);
    rdw(ctl, c);
    chk(c, 32'h0000000B, "status word at done");
    rdw(OFS_TIME_NOW, t1);
    dif = (tn ? t1[31:16] : t1[15:0]) - e[15:0];
    chk({31'h0, dif <= 16'h0002}, 32'h1, "done timing");
    chk({31'h0, irq}, {31'h0, irq_on}, "irq level");
    rdw(OFS_IRQ_STAT, c);
    chk(c, ib, "irq status");
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq after status read");
    wr(ctl, 32'h00000000);
    poll(ctl, 32'h0000000F, 32'h00000000);
    $display("run_chan %h done", ctl);
  endtask : run_chan

  // Load-once limit, reload, and stop in mid-run
  task automatic t_stop;
    logic [31:0] c;
    wr(OFS_SEC_CTRL, 32'h00000001);
    repeat (20) @(posedge mclk);
    rdw(OFS_SEC_CTRL, c);
    chk(c, 32'h00000009, "restart refused");
    wr(OFS_SEC_CTRL, 32'h00000000);
    wr(OFS_RELOAD, 32'h00000001);
    wr(OFS_SEC_PRESET, 32'h00000003);
    wr(OFS_SEC_CTRL, 32'h00000001);
    poll(OFS_SEC_CTRL, 32'h00000004, 32'h00000004);
    wr(OFS_SEC_CTRL, 32'h00000000);
    poll(OFS_SEC_CTRL, 32'h0000000F, 32'h00000000);
    repeat (200) @(posedge mclk);
    rdw(OFS_SEC_CTRL, c);
    chk(c, 32'h00000000, "no done after stop");
    rdw(OFS_IRQ_STAT, c);
    chk(c, 32'h00000000, "no event after stop");
    $display("t_stop done");
  endtask : t_stop

  // Watchdog against a hung run
  initial begin
    repeat (90000) @(posedge mclk);
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    wr(OFS_IRQ_MASK, 32'h00000003);
    run_chan(OFS_SEC_CTRL, 16'h0002, 1'b0, 32'h1, 1'b1);
    run_chan(OFS_TEN_CTRL, 16'h0003, 1'b1, 32'h2, 1'b1);
    run_chan(OFS_K_CTRL, 16'h0003, 1'b0, 32'h4, 1'b0);
    t_stop();
    give_verdict();
  end
endmodule : scan_logic_timer_unit_tb
